// File: rtl/pvic_capture.sv
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module pvic_capture
    import pvic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pixel_clk,
    input wire pvic_pkg::pvic_video_in_type video_in,
    output pvic_pkg::pvic_pixel_type pixel_out,
    output logic pixel_out_valid,
    input wire logic pixel_out_ready
);
    import pvic_pkg::*;

    localparam int PW = $bits(pvic_video_in_type);
    localparam int OW = $bits(pvic_pixel_type);

    function automatic logic [7:0] pvic_lane(input logic [23:0] bus, input logic [1:0] sel);
        logic [7:0] r;
        r = 8'h00;
        unique case (sel)
            2'd0: r = bus[7:0];
            2'd1: r = bus[15:8];
            2'd2: r = bus[23:16];
            2'd3: r = 8'h00;
        endcase
        return r;
    endfunction : pvic_lane

    // True for the five register offsets; anything else is refused.
    function automatic logic pvic_mapped(input logic [11:0] addr);
        logic hit;
        hit = 1'b0;
        unique case (addr)
            PVIC_OFS_CTRL, PVIC_OFS_MAP, PVIC_OFS_STATUS, PVIC_OFS_COUNT,
            PVIC_OFS_PIXEL: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : pvic_mapped

    // Two-flop synchronisers for the pixel clock and the video inputs.
    logic [PW:0] sync1_reg, sync2_reg, sync3_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= {pixel_clk, video_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Registers.
    logic [31:0] ctrl_reg, ctrl_next;
    logic [5:0] map_reg, map_next;
    logic overflow_reg, overflow_next;
    logic [31:0] count_reg, count_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    pvic_pixel_type last_reg, last_next;
    pvic_pixel_type out_reg, out_next;
    logic out_valid_reg, out_valid_next;

    // Video path signals.
    logic clk_now, clk_old, cap_edge, vpol, hpol, dpol;
    pvic_video_in_type vin;
    pvic_pixel_type word;
    logic accept, fifo_in_ready, fifo_out_valid, out_take;
    logic [OW-1:0] fifo_out_data;
    logic [7:0] colour [3];

    // Bus path signals.
    logic acc_first, wr_access, rd_access, clr_ovf;

    // One lane selector per colour: blue, green, red.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_lane
            assign colour[gi] = pvic_lane(vin.pixel_bus, map_reg[2*gi+:2]);
        end
    endgenerate

    always_comb begin
        clk_now = sync2_reg[PW];
        clk_old = sync3_reg[PW];
        vin = pvic_video_in_type'(sync2_reg[PW-1:0]);
        // Edge 0 selects the rising edge, as after reset.
        cap_edge = ctrl_reg[PVIC_CTRL_EDGE] ? (clk_old && !clk_now)
                                            : (!clk_old && clk_now);
        vpol = vin.frame_sync ^ ctrl_reg[PVIC_CTRL_VPOL];
        hpol = vin.line_sync ^ ctrl_reg[PVIC_CTRL_HPOL];
        dpol = vin.pixel_valid ^ ctrl_reg[PVIC_CTRL_DPOL];
        word.frame_sync = vpol;
        word.line_sync = hpol;
        word.red = colour[PVIC_MAP_RED/2];
        word.green = colour[PVIC_MAP_GREEN/2];
        word.blue = colour[PVIC_MAP_BLUE/2];
        accept = cap_edge && dpol && ctrl_reg[PVIC_CTRL_ENABLE];
    end

    pvic_fifo #(
        .WIDTH(OW),
        .DEPTH(PVIC_FIFO_DEPTH),
        .AW(PVIC_FIFO_AW)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_data(word),
        .in_valid(accept),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(out_take)
    );

    // Output stage register: holds one word, loads when empty or drained.
    always_comb begin
        out_take = fifo_out_valid && (!out_valid_reg || pixel_out_ready);
        out_next = out_reg;
        out_valid_next = out_valid_reg;
        if (out_take) begin
            out_next = pvic_pixel_type'(fifo_out_data);
            out_valid_next = 1'b1;
        end else if (pixel_out_ready) begin
            out_valid_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= '0;
            out_valid_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            out_valid_reg <= out_valid_next;
        end
    end

    // Bus handshake: one wait state, then ready for a single cycle.
    always_comb begin
        acc_first = psel && penable && !pready_reg;
        // Writes land at the edge where the master sees ready high.
        wr_access = psel && penable && pwrite && pready_reg && !pslverr_reg;
        // Read data is taken in the setup cycle and held until the next read.
        rd_access = psel && !penable && !pwrite;
        pready_next = acc_first;
        pslverr_next = acc_first && !pvic_mapped(paddr);
        prdata_next = prdata_reg;
        if (rd_access) begin
            if (pvic_mapped(paddr)) begin
                unique case (paddr)
                    PVIC_OFS_CTRL: prdata_next = ctrl_reg;
                    PVIC_OFS_MAP: prdata_next = {26'h000_0000, map_reg};
                    PVIC_OFS_STATUS: prdata_next = {29'h0000_0000, !fifo_in_ready,
                                                    fifo_out_valid, overflow_reg};
                    PVIC_OFS_COUNT: prdata_next = count_reg;
                    PVIC_OFS_PIXEL: prdata_next = {6'h00, last_reg};
                    default: prdata_next = 32'h0000_0000;
                endcase
            end else begin
                prdata_next = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Control and map registers.
    always_comb begin
        ctrl_next = ctrl_reg;
        map_next = map_reg;
        if (wr_access && paddr == PVIC_OFS_CTRL) begin
            ctrl_next = {27'h000_0000, pwdata[4:0]};
        end
        if (wr_access && paddr == PVIC_OFS_MAP) begin
            map_next = pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= PVIC_CTRL_RESET;
            map_reg <= PVIC_MAP_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            map_reg <= map_next;
        end
    end

    // Status flag, accepted pixel count and last accepted pixel.
    always_comb begin
        clr_ovf = wr_access && paddr == PVIC_OFS_STATUS && pwdata[0];
        overflow_next = overflow_reg;
        count_next = count_reg;
        last_next = last_reg;
        if (clr_ovf) begin
            overflow_next = 1'b0;
        end
        // A lost pixel sets the flag even when cleared in the same cycle.
        if (accept && !fifo_in_ready) begin
            overflow_next = 1'b1;
        end
        if (wr_access && paddr == PVIC_OFS_COUNT) begin
            count_next = 32'h0000_0000;
        end
        if (accept && fifo_in_ready) begin
            count_next = count_reg + 32'h0000_0001;
            last_next = word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            last_reg <= '0;
            overflow_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            last_reg <= last_next;
            overflow_reg <= overflow_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pixel_out = out_reg;
    assign pixel_out_valid = out_valid_reg;
endmodule : pvic_capture

// File: rtl/pvic_fifo.sv
`timescale 1ns/1ps
module pvic_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic push, pop;

    always_comb begin
        in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
        out_valid = wr_reg != rd_reg;
        out_data = mem_reg[rd_reg[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_next = wr_reg + (AW+1)'(push);
        rd_next = rd_reg + (AW+1)'(pop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            mem_reg[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule : pvic_fifo

// File: shared/pvic_pkg.sv
package pvic_pkg;

    localparam int PVIC_BUS_W = 24;
    localparam int PVIC_FIFO_DEPTH = 4;
    localparam int PVIC_FIFO_AW = 2;

    // Register byte offsets.
    localparam logic [11:0] PVIC_OFS_CTRL = 12'h000;
    localparam logic [11:0] PVIC_OFS_MAP = 12'h004;
    localparam logic [11:0] PVIC_OFS_STATUS = 12'h008;
    localparam logic [11:0] PVIC_OFS_COUNT = 12'h00C;
    localparam logic [11:0] PVIC_OFS_PIXEL = 12'h010;

    // Control register field positions.
    localparam int PVIC_CTRL_ENABLE = 0;
    localparam int PVIC_CTRL_EDGE = 1;
    localparam int PVIC_CTRL_VPOL = 2;
    localparam int PVIC_CTRL_HPOL = 3;
    localparam int PVIC_CTRL_DPOL = 4;

    // Reset values: enabled, rising edge, all signals active high.
    localparam logic [31:0] PVIC_CTRL_RESET = 32'h0000_0001;

    // Map register: three 2-bit lane selects, red at 5:4, green 3:2, blue 1:0.
    localparam int PVIC_MAP_RED = 4;
    localparam int PVIC_MAP_GREEN = 2;
    localparam int PVIC_MAP_BLUE = 0;
    localparam logic [5:0] PVIC_MAP_RESET = 6'h24;

    typedef struct packed {
        logic frame_sync;
        logic line_sync;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pvic_pixel_type;

    typedef struct packed {
        logic frame_sync;
        logic line_sync;
        logic pixel_valid;
        logic [PVIC_BUS_W-1:0] pixel_bus;
    } pvic_video_in_type;

endpackage : pvic_pkg

// File: tb/pvic_capture_chk.sv
`timescale 1ns/1ps
module pvic_capture_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pvic_pkg::pvic_pixel_type pixel_out,
    input wire logic pixel_out_valid,
    input wire logic pixel_out_ready
);
    import pvic_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    stall_hold_a: assert property (pixel_out_valid && !pixel_out_ready |=>
        pixel_out_valid && $stable(pixel_out)) else $error("Stalled pixel changed.");
    reset_quiet_a: assert property ($rose(presetn) |-> !pixel_out_valid && !pready)
        else $error("Output busy after reset.");
    ready_pulse_a: assert property (pready |=> !pready) else $error("Ready held.");
    apb_answer_a: assert property (psel && penable && !pready |-> ##[1:2] pready)
        else $error("No answer.");
    answer_inside_a: assert property (pready |-> psel && penable) else $error("Stray ready.");
    err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("Refused read gave data.");
    cover property (pixel_out_valid && pixel_out_ready);
    cover property (pixel_out_valid && !pixel_out_ready);
    cover property (pready && pslverr);
endmodule : pvic_capture_chk

bind pvic_capture pvic_capture_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .pixel_out, .pixel_out_valid, .pixel_out_ready);

// File: tb/pvic_capture_tb.sv
`timescale 1ns/1ps
module pvic_capture_tb;
    import pvic_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pixel_clk;
    pvic_video_in_type video_in;
    pvic_pixel_type pixel_out;
    logic pixel_out_valid;
    logic pixel_out_ready = 1'b1;
    logic [31:0] rd_q;
    logic err_q;
    logic [2:0] inv = '0;
    logic [5:0] cmap = PVIC_MAP_RESET;
    int error_cnt = 0;
    int samples_checked = 0;
    pvic_pixel_type exp_q[$];

    pvic_capture u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pixel_clk, .video_in, .pixel_out, .pixel_out_valid, .pixel_out_ready);
    pvic_src_model u_src (.pixel_clk, .video_in);

    always #12.5 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_px(input pvic_pixel_type got, input pvic_pixel_type exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: pixel got %h expected %h", $time, got, exp);
        end
    endtask : chk_px

    task automatic close_out();
        $display("Compares %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [7:0] lane(input logic [23:0] b, input logic [1:0] s);
        return (s == 2'h3) ? 8'h00 : b[s * 8 +: 8];
    endfunction : lane

    // Flags are frame, line, valid in their active sense; the pins carry them polarised.
    task automatic px(input logic [2:0] f, input logic [23:0] b);
        if (f[0]) begin
            exp_q.push_back({f[2:1], lane(b, cmap[5:4]), lane(b, cmap[3:2]), lane(b, cmap[1:0])});
        end
        u_src.send({f ^ inv, b});
    endtask : px

    task automatic drain();
        u_src.release_bus();
        while (exp_q.size() != 0) @(posedge pclk);
    endtask : drain

    always @(posedge pclk) begin
        if (pixel_out_valid === 1'b1 && pixel_out_ready === 1'b1) begin
            chk_px(pixel_out, exp_q.size() > 0 ? exp_q.pop_front() : 26'h3FF_FFFF);
        end
    end

    task automatic t_default();
        apb(1'b0, PVIC_OFS_MAP, '0);
        chk(rd_q, {26'h000_0000, PVIC_MAP_RESET});
        px(3'b101, 24'hA1_B2C3);
        px(3'b000, 24'h55_AA55);
        px(3'b011, 24'h0F_F00F);
        drain();
        apb(1'b0, PVIC_OFS_COUNT, '0);
        chk(rd_q, 32'h0000_0002);
    endtask : t_default

    task automatic t_edge_pol();
        apb(1'b1, PVIC_OFS_CTRL, 32'h0000_001F);
        inv = 3'b111;
        u_src.fall_cap = 1'b1;
        px(3'b111, 24'h12_3456);
        px(3'b000, 24'hED_CBA9);
        px(3'b011, 24'h65_4321);
        drain();
        apb(1'b1, PVIC_OFS_CTRL, PVIC_CTRL_RESET);
        inv = 3'b000;
        u_src.fall_cap = 1'b0;
    endtask : t_edge_pol

    task automatic t_map();
        apb(1'b1, PVIC_OFS_MAP, 32'h0000_0036);
        cmap = 6'h36;
        px(3'b001, 24'hC0_FFEE);
        px(3'b001, 24'h3C_5A96);
        drain();
        apb(1'b1, PVIC_OFS_MAP, {26'h000_0000, PVIC_MAP_RESET});
        cmap = PVIC_MAP_RESET;
        apb(1'b0, 12'h0FC, '0);
        chk({31'h0000_0000, err_q}, 32'h0000_0001);
        chk(rd_q, 32'h0000_0000);
    endtask : t_map

    task automatic t_fill();
        @(posedge pclk);
        pixel_out_ready <= 1'b0;
        // Five words fit: one in the output stage and four in the FIFO.
        for (int i = 0; i < 7; i++) begin
            if (i < 5) begin
                exp_q.push_back({2'b00, 16'h0000, 8'(i)});
            end
            u_src.send({3'b001, 24'(i)});
        end
        u_src.release_bus();
        apb(1'b0, PVIC_OFS_STATUS, '0);
        chk(rd_q, 32'h0000_0007);
        pixel_out_ready <= 1'b1;
        while (rd_q[1] !== 1'b0) apb(1'b0, PVIC_OFS_STATUS, '0);
        chk(rd_q, 32'h0000_0001);
        apb(1'b1, PVIC_OFS_STATUS, 32'h0000_0001);
        apb(1'b0, PVIC_OFS_STATUS, '0);
        chk(rd_q, 32'h0000_0000);
        chk(32'(exp_q.size()), 32'h0000_0000);
    endtask : t_fill

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_default();
        t_edge_pol();
        t_map();
        t_fill();
        close_out();
    end

    initial begin
        #50_000;
        error_cnt++;
        close_out();
    end
endmodule : pvic_capture_tb

// File: tb/pvic_src_model.sv
`timescale 1ns/1ps
module pvic_src_model (
    output logic pixel_clk,
    output pvic_pkg::pvic_video_in_type video_in
);
    import pvic_pkg::*;
    logic fall_cap = 1'b0;
    initial begin
        pixel_clk = 1'b0;
        video_in = '0;
    end
    // The word changes on the idle edge, half a period clear of the capture edge.
    task automatic send(input pvic_video_in_type word);
        pixel_clk = fall_cap;
        video_in = word;
        #100 pixel_clk = ~fall_cap;
        #100 pixel_clk = 1'b0;
    endtask : send
    // Between frames the clock stands low and the bus carries the inverse of the last word.
    task automatic release_bus();
        video_in = ~video_in;
    endtask : release_bus
endmodule : pvic_src_model
